/* File: rtl/ddr_burst2_sram_port.sv */
// Two-word burst double-data-rate SRAM port, device side
//
// Summary of operation
// - Write words are taken on rising edges of both input strobes, one per edge.
// - Read words launch on both output strobe rises, input strobes in single mode.
// - Data pins are released whenever no read word is being driven.
// - Every read or write moves exactly two words as one burst.
// - Active-low byte selects are sampled on the same edge as their data word.
// - A lane with its select high keeps its stored contents unchanged.
// - Each select governs one 9-bit lane, select 0 owning the lowest bits.
// - Data bus is 18 bits deep or 36 bits wide on shared pins.
// - One address bus serves both directions; storage is two half arrays.
// - The burst start bit seeds a one-bit linear counter for the second word.
// - Deep organisation uses 21 address inputs plus the burst start bit, wide uses 20.
// - Address inputs are ignored while no cycle is loaded.
// - With load low, direction high means read and low means write.
// - Read data is clocked out by the true and inverse output strobes, or by the input pair in single mode.
// - Every access starts on a true input strobe rise, capturing address, burst start bit and command.
// - Loop enabled gives 1.5 cycle read latency; loop disabled gives one cycle.
// - Inverse input strobe rise captures write data and launches reads in single mode.
`timescale 1ns/1ns
module ddr_burst2_sram_port
  import ddr_burst2_pkg::*;
#(
  parameter bit WIDE_ORG = 1'h0,
  localparam int DW = WIDE_ORG ? WIDE_DATA_W : DEEP_DATA_W,
  localparam int AW = WIDE_ORG ? WIDE_ADDR_W : DEEP_ADDR_W,
  localparam int IW = AW - 1,
  localparam int LANES = DW / LANE_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic c_i,
  input wire logic c_n_i,
  input wire logic single_clock_mode_i,
  input wire logic loop_disable_n_i,
  input wire logic cycle_load_n_i,
  input wire logic read_write_i,
  input wire logic burst_start_bit_i,
  input wire logic [IW-1:0] addr_i,
  input wire logic [LANES-1:0] byte_write_sel_n_i,
  input wire logic [DW-1:0] dq_i,
  output logic [DW-1:0] dq_o,
  output logic dq_oe_o
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  localparam int SW = CTRL_SYNC_W + IW + LANES + DW;
  localparam int DEPTH = 1 << IW;

  typedef struct packed {
    logic vld;
    logic [AW-1:0] addr;
  } slot_t;

  logic [SW-1:0] async_vec;
  logic [SW-1:0] sync_vec;
  logic k_s;
  logic kn_s;
  logic c_s;
  logic cn_s;
  logic scm_s;
  logic loop_n_s;
  logic load_n_s;
  logic rw_s;
  logic start_s;
  logic [IW-1:0] addr_s;
  logic [LANES-1:0] sel_n_s;
  logic [DW-1:0] dq_s;

  // Data and selects pass the same two stages as the strobes, so the
  // value seen at a detected edge is the one present at that edge
  assign async_vec = {k_i, k_n_i, c_i, c_n_i, single_clock_mode_i, loop_disable_n_i,
                      cycle_load_n_i, read_write_i, burst_start_bit_i, addr_i,
                      byte_write_sel_n_i, dq_i};

  sync_stage2 #(
    .W(SW)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(async_vec),
    .q_o(sync_vec)
  );

  assign {k_s, kn_s, c_s, cn_s, scm_s, loop_n_s, load_n_s, rw_s, start_s, addr_s,
          sel_n_s, dq_s} = sync_vec;

  // ----------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------
  logic lc_s;
  logic lcn_s;
  logic k_d_reg;
  logic k_d_next;
  logic kn_d_reg;
  logic kn_d_next;
  logic lc_d_reg;
  logic lc_d_next;
  logic lcn_d_reg;
  logic lcn_d_next;
  logic k_rise;
  logic kn_rise;
  logic launch;

  // Output strobe pair, or the input pair when none is supplied
  assign lc_s = scm_s ? k_s : c_s;
  assign lcn_s = scm_s ? kn_s : cn_s;

  always_comb begin
    k_d_next = k_s;
    kn_d_next = kn_s;
    lc_d_next = lc_s;
    lcn_d_next = lcn_s;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      k_d_reg <= 1'h0;
      kn_d_reg <= 1'h0;
      lc_d_reg <= 1'h0;
      lcn_d_reg <= 1'h0;
    end else begin
      k_d_reg <= k_d_next;
      kn_d_reg <= kn_d_next;
      lc_d_reg <= lc_d_next;
      lcn_d_reg <= lcn_d_next;
    end
  end

  assign k_rise = k_s & ~k_d_reg;
  assign kn_rise = kn_s & ~kn_d_reg;
  assign launch = (lc_s & ~lc_d_reg) | (lcn_s & ~lcn_d_reg);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic load_rd;
  logic load_wr;
  logic [AW-1:0] load_addr;

  // Address is only looked at when a cycle is loaded
  assign load_rd = k_rise & ~load_n_s & rw_s;
  assign load_wr = k_rise & ~load_n_s & ~rw_s;
  assign load_addr = {addr_s, start_s};

  // ----------------------------------------------------------------
  // Write sequencer
  // ----------------------------------------------------------------
  wr_state_t wr_state_reg;
  wr_state_t wr_state_next;
  logic [AW-1:0] wr_addr_reg;
  logic [AW-1:0] wr_addr_next;
  logic we;
  logic [AW-1:0] we_addr;

  // Word 0 on the next inverse strobe rise, word 1 on the true rise after;
  // that true rise may load the next command in the same cycle
  always_comb begin
    wr_state_next = wr_state_reg;
    wr_addr_next = wr_addr_reg;
    we = 1'h0;
    we_addr = wr_addr_reg;
    unique case (wr_state_reg)
      WR_IDLE: begin
        wr_state_next = WR_IDLE;
      end
      WR_WORD0: begin
        if (kn_rise) begin
          we = 1'h1;
          wr_state_next = WR_WORD1;
        end
      end
      WR_WORD1: begin
        if (k_rise) begin
          we = 1'h1;
          we_addr = {wr_addr_reg[AW-1:1], ~wr_addr_reg[0]};
          wr_state_next = WR_IDLE;
        end
      end
      default: begin
        wr_state_next = WR_IDLE;
      end
    endcase
    if (load_wr) begin
      wr_addr_next = load_addr;
      wr_state_next = WR_WORD0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_state_reg <= WR_IDLE;
      wr_addr_reg <= '0;
    end else begin
      wr_state_reg <= wr_state_next;
      wr_addr_reg <= wr_addr_next;
    end
  end

  // ----------------------------------------------------------------
  // Storage: two arrays selected by the burst bit
  // ----------------------------------------------------------------
  logic [DW-1:0] mem [ARRAY_N][DEPTH];

  // Storage has no reset; its contents are undefined until written
  always_ff @(posedge ref_clk_i) begin
    if (we) begin
      for (int l = 0; l < LANES; l++) begin
        if (!sel_n_s[l]) begin
          mem[we_addr[0]][we_addr[AW-1:1]][l*LANE_W +: LANE_W] <=
            dq_s[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read launch schedule
  // ----------------------------------------------------------------
  slot_t [SLOT_N-1:0] slot_reg;
  slot_t [SLOT_N-1:0] slot_next;
  logic fire;
  logic [AW-1:0] fire_addr;
  logic [DW-1:0] dq_reg;
  logic [DW-1:0] dq_next;
  logic dq_oe_reg;
  logic dq_oe_next;
  int first_slot;

  // Slot i fires at launch edge i+1 counted from now. The launch edge that
  // coincides with the load is the load's own edge and does not count, so
  // the output strobes must not lag the input strobes by a sample period.
  always_comb begin
    first_slot = loop_n_s ? LOOP_ON_FIRST_SLOT : LOOP_OFF_FIRST_SLOT;
    slot_next = slot_reg;
    fire = launch & slot_reg[0].vld;
    fire_addr = slot_reg[0].addr;
    if (launch) begin
      for (int i = 0; i < SLOT_N - 1; i++) begin
        slot_next[i] = slot_reg[i+1];
      end
      slot_next[SLOT_N-1] = '0;
    end
    if (load_rd) begin
      for (int w = 0; w < BURST_LEN; w++) begin
        slot_next[first_slot + w].vld = 1'h1;
        slot_next[first_slot + w].addr = {addr_s, start_s ^ w[0]};
      end
    end
    dq_next = dq_reg;
    dq_oe_next = dq_oe_reg;
    if (launch) begin
      dq_oe_next = fire;
      if (fire) begin
        dq_next = mem[fire_addr[0]][fire_addr[AW-1:1]];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_reg <= '0;
      dq_reg <= '0;
      dq_oe_reg <= 1'h0;
    end else begin
      slot_reg <= slot_next;
      dq_reg <= dq_next;
      dq_oe_reg <= dq_oe_next;
    end
  end

  assign dq_o = dq_reg;
  assign dq_oe_o = dq_oe_reg;

endmodule : ddr_burst2_sram_port

/* File: rtl/ddr_burst2_pkg.sv */
// Constants shared by the two-word burst DDR SRAM port
package ddr_burst2_pkg;

  // ----------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------
  localparam int LANE_W = 9;
  localparam int DEEP_DATA_W = 18;
  localparam int WIDE_DATA_W = 36;
  // Address widths count the burst start bit as well
  localparam int DEEP_ADDR_W = 22;
  localparam int WIDE_ADDR_W = 21;
  localparam int BURST_LEN = 2;
  localparam int ARRAY_N = 2;

  // ----------------------------------------------------------------
  // Synchroniser layout and read launch schedule
  // ----------------------------------------------------------------
  // Strobes k, k_n, c, c_n, mode, loop, load, direction, burst bit
  localparam int CTRL_SYNC_W = 9;
  // One slot per launch edge still to come
  localparam int SLOT_N = 4;
  // Slot of the first read word: loop on fires at the third launch edge
  localparam int LOOP_ON_FIRST_SLOT = 2;
  // Loop off fires at the second launch edge (one cycle)
  localparam int LOOP_OFF_FIRST_SLOT = 1;

  // ----------------------------------------------------------------
  // Write sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WR_IDLE  = 3'h1,
    WR_WORD0 = 3'h2,
    WR_WORD1 = 3'h4
  } wr_state_t;

endpackage : ddr_burst2_pkg

/* File: rtl/sync_stage2.sv */
// Two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ns
module sync_stage2 #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] hold_reg;

  // The first stage feeds only the second stage
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      hold_reg <= '0;
    end else begin
      meta_reg <= d_i;
      hold_reg <= meta_reg;
    end
  end

  assign q_o = hold_reg;

endmodule : sync_stage2

/* File: tb/ddr_burst2_props.sv */
// Checker for the read launch timing of the burst SRAM port
`timescale 1ns/1ns
module ddr_burst2_props
  import ddr_burst2_pkg::*;
#(
  parameter bit WIDE_ORG = 1'h0,
  localparam int DW = WIDE_ORG ? WIDE_DATA_W : DEEP_DATA_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic c_i,
  input wire logic c_n_i,
  input wire logic single_clock_mode_i,
  input wire logic loop_disable_n_i,
  input wire logic cycle_load_n_i,
  input wire logic read_write_i,
  input wire logic [DW-1:0] dq_o,
  input wire logic dq_oe_o
);
  logic [3:0] pin_reg;
  logic [4:0] since_reg;
  logic [4:0] since_next;
  logic launch;
  logic rd_load;

  // Pin edges are seen here one cycle after the pins move; outputs lag that by three
  always_comb begin
    launch = single_clock_mode_i ? (k_i & ~pin_reg[3]) | (k_n_i & ~pin_reg[2])
                                 : (c_i & ~pin_reg[1]) | (c_n_i & ~pin_reg[0]);
    rd_load = k_i & ~pin_reg[3] & ~cycle_load_n_i & read_write_i;
    since_next = rd_load ? 5'h0 : (since_reg == 5'h1f ? since_reg : since_reg + 5'h1);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_reg <= 4'h0;
      since_reg <= 5'h1f;
    end else begin
      pin_reg <= {k_i, k_n_i, c_i, c_n_i};
      since_reg <= since_next;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_rst_quiet; $past(rst_n_i) == 1'b0 |-> !dq_oe_o && !(|dq_o); endproperty
  property p_dq_hold; $changed(dq_o) |-> $past(launch, 3); endproperty
  property p_oe_hold; $changed(dq_oe_o) |-> $past(launch, 3); endproperty
  property p_lat_off; rd_load && !loop_disable_n_i |-> ##11 dq_oe_o; endproperty
  property p_lat_on; rd_load && loop_disable_n_i |-> ##15 dq_oe_o; endproperty
  property p_burst_len; $rose(dq_oe_o) |-> dq_oe_o[*8]; endproperty
  property p_no_stray; dq_oe_o |-> since_reg < 5'h16; endproperty
  property p_release; $fell(dq_oe_o) |-> since_reg >= 5'h12; endproperty

  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not idle after reset");
  a_dq_hold: assert property (p_dq_hold)
    else $error("read data moved off a launch edge");
  a_oe_hold: assert property (p_oe_hold)
    else $error("drive enable moved off a launch edge");
  a_lat_off: assert property (p_lat_off)
    else $error("one cycle read word missing");
  a_lat_on: assert property (p_lat_on)
    else $error("cycle and a half read word missing");
  a_burst_len: assert property (p_burst_len)
    else $error("read burst shorter than two words");
  a_no_stray: assert property (p_no_stray)
    else $error("data pins driven with no read");
  a_release: assert property (p_release)
    else $error("data pins released too early");

  c_rd_off: cover property (rd_load && !loop_disable_n_i);
  c_rd_on: cover property (rd_load && loop_disable_n_i);
  c_single: cover property (single_clock_mode_i && $rose(dq_oe_o));
endmodule : ddr_burst2_props

bind ddr_burst2_sram_port ddr_burst2_props #(.WIDE_ORG(WIDE_ORG)) u_props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .k_i(k_i), .k_n_i(k_n_i), .c_i(c_i),
  .c_n_i(c_n_i), .single_clock_mode_i(single_clock_mode_i),
  .loop_disable_n_i(loop_disable_n_i), .cycle_load_n_i(cycle_load_n_i),
  .read_write_i(read_write_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o)
);

/* File: tb/ddr_burst2_ctl_model.sv */
// Memory controller model: strobes, commands, write data and read capture
`timescale 1ns/1ns
module ddr_burst2_ctl_model #(
  parameter int IW = 21,
  parameter int DW = 18,
  parameter int LANES = 2
) (
  input wire logic ref_clk_i,
  input wire logic c_run_i,
  input wire logic [DW-1:0] dq_i,
  input wire logic dq_oe_i,
  output logic k_o,
  output logic k_n_o,
  output logic c_o,
  output logic c_n_o,
  output logic cycle_load_n_o,
  output logic read_write_o,
  output logic burst_start_bit_o,
  output logic [IW-1:0] addr_o,
  output logic [LANES-1:0] byte_write_sel_n_o,
  output logic [DW-1:0] dq_o
);
  typedef struct packed {
    logic load;
    logic rd;
    logic [IW-1:0] a;
    logic b;
    logic [DW-1:0] d0;
    logic [DW-1:0] d1;
    logic [LANES-1:0] s0;
    logic [LANES-1:0] s1;
  } op_t;
  op_t q[$];
  op_t cur;
  logic [DW-1:0] rdq[$];
  int rde[$];
  int rel = 0;
  bit w0 = 1'b0;
  bit w1 = 1'b0;
  logic [2:0] cnt = 3'h0;
  logic [2:0] nx;

  initial begin
    {k_o, k_n_o, c_o, c_n_o, cycle_load_n_o, read_write_o, burst_start_bit_o} = 7'h04;
    addr_o = '0;
    byte_write_sel_n_o = '1;
    dq_o = '0;
  end

  task automatic issue(input logic load, input logic rd, input logic [IW-1:0] a, input logic b,
                       input logic [DW-1:0] d0, input logic [DW-1:0] d1,
                       input logic [LANES-1:0] s0, input logic [LANES-1:0] s1);
    q.push_back({load, rd, a, b, d0, d1, s0, s1});
  endtask : issue

  // ----------------------------------------------------------------
  // Eight reference cycles per strobe period; inputs settle one cycle before each rise
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    nx = cnt + 3'h1;
    cnt <= nx;
    k_o <= ~nx[2];
    k_n_o <= nx[2];
    c_o <= c_run_i & ~nx[2];
    c_n_o <= c_run_i & nx[2];
    if (cnt == 3'h3 || cnt == 3'h7) begin
      if (dq_oe_i) begin
        rdq.push_back(dq_i);
        rde.push_back(rel);
      end
      rel = rel + 1;
    end
    if (cnt == 3'h7 && !cycle_load_n_o && read_write_o) rel = 0;
    if (cnt == 3'h6) begin
      // Released lines show the inverse so a stale value never passes
      if (w1) begin
        dq_o <= cur.d1;
        byte_write_sel_n_o <= cur.s1;
      end else begin
        dq_o <= ~dq_o;
        byte_write_sel_n_o <= ~byte_write_sel_n_o;
      end
      w1 = 1'b0;
      if (q.size() > 0) begin
        cur = q.pop_front();
        cycle_load_n_o <= ~cur.load;
        read_write_o <= cur.rd;
        addr_o <= cur.a;
        burst_start_bit_o <= cur.b;
        w0 = ~cur.rd;
      end
    end
    if (cnt == 3'h2) begin
      cycle_load_n_o <= 1'b1;
      read_write_o <= ~read_write_o;
      addr_o <= ~addr_o;
      burst_start_bit_o <= ~burst_start_bit_o;
      if (w0) begin
        dq_o <= cur.d0;
        byte_write_sel_n_o <= cur.s0;
        w1 = 1'b1;
      end else begin
        dq_o <= ~dq_o;
        byte_write_sel_n_o <= ~byte_write_sel_n_o;
      end
      w0 = 1'b0;
    end
  end
endmodule : ddr_burst2_ctl_model

/* File: tb/ddr_burst2_sram_port_bench.sv */
// Self-checking bench for the two-word burst SRAM port
`timescale 1ns/1ns
module ddr_burst2_sram_port_bench;
  import ddr_burst2_pkg::*;
  localparam int IW = DEEP_ADDR_W - 1;
  localparam int DW = DEEP_DATA_W;
  localparam int LANES = DW / LANE_W;
  localparam logic [IW-1:0] AL = 21'h0abcd;
  localparam logic [IW-1:0] AT = 21'h1fffff;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sm = 1'b0;
  logic lp = 1'b0;
  logic crun = 1'b1;
  logic k, kn, c, cn, load_n, rw, b, oe;
  logic [IW-1:0] a;
  logic [LANES-1:0] lane_sel;
  logic [DW-1:0] wd, rdat;
  int n_fail = 0;
  int n_compared = 0;

  always #20 ref_clk = ~ref_clk;

  ddr_burst2_sram_port #(.WIDE_ORG(1'h0)) u_dut (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .k_i(k), .k_n_i(kn), .c_i(c), .c_n_i(cn),
    .single_clock_mode_i(sm), .loop_disable_n_i(lp), .cycle_load_n_i(load_n),
    .read_write_i(rw), .burst_start_bit_i(b), .addr_i(a), .byte_write_sel_n_i(lane_sel),
    .dq_i(wd), .dq_o(rdat), .dq_oe_o(oe));

  ddr_burst2_ctl_model #(.IW(IW), .DW(DW), .LANES(LANES)) u_ctl (
    .ref_clk_i(ref_clk), .c_run_i(crun), .dq_i(rdat), .dq_oe_i(oe), .k_o(k), .k_n_o(kn),
    .c_o(c), .c_n_o(cn), .cycle_load_n_o(load_n), .read_write_o(rw), .burst_start_bit_o(b),
    .addr_o(a), .byte_write_sel_n_o(lane_sel), .dq_o(wd));

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset(input logic s, input logic l);
    rst_n <= 1'b0;
    sm <= s;
    lp <= l;
    crun <= ~s;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : do_reset

  task automatic wr(input logic [IW-1:0] ad, input logic bb, input logic [DW-1:0] d0,
                    input logic [DW-1:0] d1, input logic [1:0] s0, input logic [1:0] s1);
    u_ctl.issue(1'b1, 1'b0, ad, bb, d0, d1, s0, s1);
  endtask : wr

  // Waits for the burst, then lingers so a third word would be caught
  task automatic rd(input logic [IW-1:0] ad, input logic bb, input logic [DW-1:0] e0,
                    input logic [DW-1:0] e1, input int fe);
    u_ctl.rdq.delete();
    u_ctl.rde.delete();
    u_ctl.issue(1'b1, 1'b1, ad, bb, '0, '0, '0, '0);
    for (int i = 0; i < 80 && u_ctl.rdq.size() < 2; i++) @(posedge ref_clk);
    repeat (16) @(posedge ref_clk);
    chk(DW'(u_ctl.rdq.size()), 18'h2);
    if (u_ctl.rdq.size() == 2) begin
      chk(u_ctl.rdq[0], e0);
      chk(u_ctl.rdq[1], e1);
      chk(DW'(u_ctl.rde[0]), DW'(fe));
      chk(DW'(u_ctl.rde[1]), DW'(fe + 1));
    end
  endtask : rd

  task automatic t_data;
    wr(AL, 1'b0, 18'h2a5c3, 18'h1b7e4, 2'h0, 2'h0);
    rd(AL, 1'b0, 18'h2a5c3, 18'h1b7e4, 2);
    rd(AL, 1'b1, 18'h1b7e4, 18'h2a5c3, 2);
    wr(AT, 1'b1, 18'h3c0f0, 18'h00f0f, 2'h0, 2'h0);
    rd(AT, 1'b1, 18'h3c0f0, 18'h00f0f, 2);
    wr(AL, 1'b0, 18'h155aa, 18'h0ff33, 2'h2, 2'h1);
    rd(AL, 1'b0, 18'h2a400 | 18'h001aa, 18'h0fe00 | 18'h001e4, 2);
    u_ctl.issue(1'b0, 1'b0, AL, 1'b0, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
    rd(AL, 1'b0, 18'h2a5aa, 18'h0ffe4, 2);
    $display("test data done");
  endtask : t_data

  task automatic t_modes;
    do_reset(1'b0, 1'b1);
    rd(AT, 1'b1, 18'h3c0f0, 18'h00f0f, 3);
    do_reset(1'b1, 1'b0);
    rd(AT, 1'b0, 18'h00f0f, 18'h3c0f0, 2);
    $display("test modes done");
  endtask : t_modes

  task automatic test_done;
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    do_reset(1'b0, 1'b0);
    t_data();
    t_modes();
    test_done();
  end

  // About 350 reference cycles are expected; the 10,000-cycle limit allows far more than that
  initial begin
    #400000;
    n_fail++;
    test_done();
  end
endmodule : ddr_burst2_sram_port_bench
